// file: bench/cmwa_core_model.sv
// Behavioural core memory facing the adapter's core port
`timescale 1ns/1ps
module cmwa_core_model (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     resetn,
  // Pacing
  input  wire logic                     slow,
  // Core side
  input  wire cmwa_pkg::cmwa_core_req_t core_req,
  output logic                          core_ack,
  output logic       [17:0]             core_rdata
);
  import cmwa_pkg::*;
  logic [17:0] mem [int];

  function automatic logic [17:0] peek(input int a);
    return mem.exists(a) ? mem[a] : 18'((a * 37) ^ 32'h2A5A5);
  endfunction

  // ----------------------------------------------------------------
  // Answer, stalling at random when slow
  // ----------------------------------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      core_ack   <= 1'b0;
      core_rdata <= 18'h3FFFF;
    end else if (!core_ack && core_req.valid && (!slow || $urandom % 3 == 0)) begin
      core_ack <= 1'b1;
      if (core_req.write)
        mem[int'(core_req.addr)] = (peek(core_req.addr) & ~core_req.wmask) | (core_req.wdata & core_req.wmask);
      else
        core_rdata <= peek(core_req.addr);
    end else begin
      core_ack   <= 1'b0;
      core_rdata <= ~core_rdata;
    end
  end
endmodule // cmwa_core_model

// file: bench/cmwa_top_tb.sv
// Self-checking bench for the core memory width adapter
`timescale 1ns/1ps
module cmwa_top_tb;
  import cmwa_pkg::*;
  logic           clock      = 1'b0;
  logic           resetn     = 1'b0;
  logic           clock_en   = 1'b1;
  logic           psel       = 1'b0;
  logic           penable    = 1'b0;
  logic           pwrite     = 1'b0;
  logic [11:0]    paddr      = 12'h000;
  logic [31:0]    pwdata     = 32'h00000000;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  cmwa_cpu_req_t  cpu_req    = '0;
  logic           cpu_ack;
  logic [15:0]    cpu_rdata;
  cmwa_core_req_t core_req;
  logic           core_ack;
  logic [17:0]    core_rdata;
  logic           slow       = 1'b0;
  int             mismatches = 0;
  int             compares   = 0;
  int             acks       = 0;
  int             ref_mem [int];
  int             last [2];
  logic [31:0]    rd;
  logic           err;

  always #2.5 clock = ~clock;

  cmwa_top uut (.clock(clock), .resetn(resetn), .clock_en(clock_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_req(cpu_req), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .core_req(core_req), .core_ack(core_ack),
    .core_rdata(core_rdata));
  cmwa_core_model partner (.clock(clock), .resetn(resetn), .slow(slow), .core_req(core_req),
    .core_ack(core_ack), .core_rdata(core_rdata));

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] exp, input logic [31:0] act);
    compares++;
    if (act !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: expected %h, got %h", $time, exp, act);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      conclude();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cpu(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic want);
    int n;
    @(posedge clock);
    cpu_req <= '{1'b1, wr, a, d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (cpu_ack !== 1'b1 && n < 40);
    rd = {16'h0000, cpu_rdata};
    if (cpu_ack === 1'b1)
      acks++;
    check({31'h0, want}, {31'h0, cpu_ack === 1'b1});
    if (want && cpu_ack !== 1'b1)
      conclude();
    cpu_req.valid <= 1'b0;
    @(posedge clock);
  endtask

  function automatic int word(input int a);
    return ref_mem.exists(a) ? ref_mem[a] : ((a * 37) ^ 32'h2A5A5) & 32'h3FFFF;
  endfunction

  // ----------------------------------------------------------------
  // One processor access checked against the reference
  // ----------------------------------------------------------------
  task automatic access(input logic m, input logic [3:0] pg, input logic wr, input int off, input int d);
    int ca;
    int w;
    int hi;
    ca = m ? {pg, 13'(off >> 1)} : {pg[2:0], 14'(off)};
    hi = (off >> 1) & 1;
    w  = word(ca);
    if (wr) begin
      if (!m)
        w = (w & 32'h20100) | (d & 32'hFF) | ((d & 32'hFF00) << 1);
      else if (hi)
        w = (w & 32'h1FF) | ((d & 32'h1FF) << 9);
      else
        w = (w & 32'h3FE00) | (d & 32'h1FF);
      ref_mem[ca] = w;
    end
    cpu(wr, 16'(32'h6000 + off), 16'(d), 1'b1);
    if (wr)
      check(w, {14'h0, partner.peek(ca)});
    else if (!m)
      check((w & 32'hFF) | ((w >> 1) & 32'hFF00), rd);
    else
      check(hi ? (w >> 9) & 32'h1FF : w & 32'h1FF, rd);
    if (!wr)
      last[ca & 1] = w;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [3:0] pg;
    logic       m;
    void'($urandom(71));
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    check(32'h0, rd);
    apb(1'b0, REG_WIN_BASE, 32'h0);
    check(32'h6000, rd);
    apb(1'b0, REG_WIN_SIZE, 32'h0);
    check(32'h8000, rd);
    apb(1'b1, 12'hFF0, 32'h1);
    check(32'h1, {31'h0, err});
    apb(1'b0, 12'hFF0, 32'h0);
    check(32'h1, {31'h0, err});
    check(32'h0, rd);
    cpu(1'b0, 16'h6000, 16'h0000, 1'b0);
    for (int i = 0; i < 60; i++) begin
      m    = 1'($urandom % 2);
      pg   = 4'($urandom % 16);
      slow <= 1'($urandom % 2);
      apb(1'b1, REG_CTRL, {23'h0, 1'b1, pg, 3'h0, m});
      apb(1'b0, REG_CTRL, 32'h0);
      check({23'h0, 1'b1, pg, 3'h0, m}, rd);
      repeat (3) access(m, pg, 1'($urandom % 2),
        ($urandom % 8) * 2 + (m ? 0 : $urandom % 2) + ($urandom % 2) * 32'h2000,
        $urandom % 65536);
    end
    // Frozen adapter takes no request
    clock_en <= 1'b0;
    cpu(1'b0, 16'h6000, 16'h0000, 1'b0);
    clock_en <= 1'b1;
    apb(1'b0, REG_STATUS, 32'h0);
    check((acks % 64) << 8, rd);
    cpu(1'b0, 16'h5FFE, 16'h0000, 1'b0);
    cpu(1'b1, 16'hE000, 16'h1234, 1'b0);
    apb(1'b1, REG_CTRL, {23'h0, 1'b1, 4'h5, 3'h0, 1'b1});
    access(1'b1, 4'h5, 1'b0, 0, 0);
    access(1'b1, 4'h5, 1'b0, 2, 0);
    apb(1'b0, REG_PIX_LO, 32'h0);
    check(last[0], rd);
    apb(1'b0, REG_PIX_HI, 32'h0);
    check(last[1], rd);
    conclude();
  end

  initial begin
    #300000;
    mismatches++;
    conclude();
  end
endmodule // cmwa_top_tb

// file: verilog/cmwa_pkg.sv
// Package for the core memory width adapter
package cmwa_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CPU_DATA_W  = 16;
  localparam int CORE_DATA_W = 18;
  localparam int CPU_ADDR_W  = 16;
  localparam int CORE_ADDR_W = 17;
  localparam int HALF_W      = 9;
  localparam int BYTE_W      = 8;
  localparam int PAGE_W      = 4;
  localparam int PIXEL_W     = 6;
  localparam int PIXELS      = 6;

  // ----------------------------------------------------------------
  // Address window in the processor space (byte address)
  // ----------------------------------------------------------------
  localparam logic [15:0] WIN_BASE_RESET = 16'h6000;
  localparam logic [15:0] WIN_SIZE_RESET = 16'h8000;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_WIN_BASE = 12'h004;
  localparam logic [11:0] REG_WIN_SIZE = 12'h008;
  localparam logic [11:0] REG_STATUS   = 12'h00C;
  localparam logic [11:0] REG_PIX_LO   = 12'h010;
  localparam logic [11:0] REG_PIX_HI   = 12'h014;

  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_PAGE_LSB = 4;
  localparam int CTRL_EN_BIT   = 8;

  localparam logic [3:0] PAGE_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Core write masks and byte select
  // ----------------------------------------------------------------
  localparam logic [17:0] CPU_WMASK      = 18'h1FEFF;
  localparam logic [17:0] LOW_HALF_MASK  = 18'h001FF;
  localparam logic [17:0] HIGH_HALF_MASK = 18'h3FE00;
  localparam int          BYTE_SEL_BIT   = 1;

  typedef enum logic {
    CMWA_MODE_CPU  = 1'b0,
    CMWA_MODE_NINE = 1'b1
  } cmwa_mode_t;

  // Processor side request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cmwa_cpu_req_t;

  // Core side request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [16:0] addr;
    logic [17:0] wdata;
    logic [17:0] wmask;
  } cmwa_core_req_t;

endpackage

// file: verilog/cmwa_steer.sv
// Data and address steering between processor word and core word
`timescale 1ns/1ps
module cmwa_steer (
  // Settings
  input  wire cmwa_pkg::cmwa_mode_t mode,
  input  wire logic [3:0]           page,
  // Processor side
  input  wire logic [15:0]          cpu_address_bit,
  input  wire logic [15:0]          cpu_data_bit,
  // Core side
  input  wire logic [17:0]          core_data_bit,
  output logic      [16:0]          core_address_bit,
  output logic      [17:0]          core_wdata,
  output logic      [17:0]          core_wmask,
  output logic      [15:0]          cpu_rdata
);
  import cmwa_pkg::*;

  logic high_half;

  always_comb begin
    high_half = cpu_address_bit[BYTE_SEL_BIT];
    if (mode == CMWA_MODE_CPU) begin
      core_address_bit = {page[2:0], cpu_address_bit[13:0]};      // [RL10] [RL14]
      core_wdata       = {1'b0, cpu_data_bit[15:8], 1'b0, cpu_data_bit[7:0]}; // [RL1]
      core_wmask       = CPU_WMASK;                               // [RL2]
      cpu_rdata        = {core_data_bit[16:9], core_data_bit[7:0]}; // [RL3]
    end else begin
      core_address_bit = {page, cpu_address_bit[13:1]};           // [RL9] [RL15]
      core_wdata       = {cpu_data_bit[8:0], cpu_data_bit[8:0]};  // [RL4] [RL6]
      core_wmask       = high_half ? HIGH_HALF_MASK : LOW_HALF_MASK; // [RL4]
      cpu_rdata        = {7'h00, high_half ? core_data_bit[17:9]
                                           : core_data_bit[8:0]}; // [RL5] [RL6]
    end
  end

endmodule // cmwa_steer

// file: verilog/cmwa_top.sv
// Core memory width adapter with APB control registers
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// RL1 - A processor-mode write puts cpu bits 0-7 in core bits 0-7 and cpu bits 8-15 in core bits 9-16.
// RL2 - A processor-mode write leaves core bits 8 and 17 unwritten.
// RL3 - A processor-mode read returns core bits 0-7 and 9-16 as cpu bits 0-15, ignoring bits 8 and 17.
// RL4 - A 9-bit-mode write puts cpu bits 0-8 into the low or high core half chosen by the byte select bit.
// RL5 - A 9-bit-mode read muxes core bits 0-8 or 9-17 onto cpu bits 0-8 by the same select bit.
// RL6 - In 9-bit mode cpu bits 9-15 are ignored on writes and read back as zero.
// RL7 - Software sets 8-bit or 9-bit steering in the mode control before accessing the core.
// RL8 - Software picks the visible 8K page by writing page bits in an I/O register.
// RL9 - 9-bit mode uses four page bits, reaching sixteen 8K pages.
// RL10 - Processor mode uses only three page bits.
// RL11 - In refresh use two 18-bit words form six 6-bit pixels.
// RL12 - The core is 128K words of 18 bits holding 6-bit video values.
// RL13 - The reconfigured core answers only inside the gap between installed memory and the I/O region.
// RL14 - Processor mode address is cpu address bits 0-13 plus three held page bits.
// RL15 - 9-bit mode uses word transfers, address bits 1-13 plus four page bits, bit 1 as byte select.
// RL16 - New mode and page settings apply to every later access and alter no stored data.
module cmwa_top (
  // Clock and reset
  input  wire  logic                    clock,
  input  wire  logic                    resetn,
  input  wire  logic                    clock_en,
  // APB slave
  input  wire  logic                    psel,
  input  wire  logic                    penable,
  input  wire  logic                    pwrite,
  input  wire  logic [11:0]             paddr,
  input  wire  logic [31:0]             pwdata,
  output logic       [31:0]             prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Processor side (same clock)
  input  wire  cmwa_pkg::cmwa_cpu_req_t cpu_req,
  output logic                          cpu_ack,
  output logic       [15:0]             cpu_rdata,
  // Core memory side
  output cmwa_pkg::cmwa_core_req_t      core_req,
  input  wire  logic                    core_ack,
  input  wire  logic [17:0]             core_rdata
);
  import cmwa_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  cmwa_mode_t  mode, next_mode;
  logic [3:0]  page, next_page;
  logic        enable, next_enable;
  logic [15:0] win_base, next_win_base;
  logic [15:0] win_size, next_win_size;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [35:0] pix_pair, next_pix_pair;
  logic [5:0]  hit_count, next_hit_count;

  // ----------------------------------------------------------------
  // Access state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CMWA_IDLE, CMWA_BUSY, CMWA_DONE} cmwa_state_t;
  cmwa_state_t    state, next_state;
  cmwa_core_req_t next_core_req;
  logic           next_cpu_ack;
  logic [15:0]    next_cpu_rdata;

  logic [16:0] st_addr;
  logic [17:0] st_wdata;
  logic [17:0] st_wmask;
  logic [15:0] st_rdata;
  logic        in_window;
  logic [15:0] win_offset;

  cmwa_steer u_steer (
    .mode             (mode),
    .page             (page),
    .cpu_address_bit  (win_offset),
    .cpu_data_bit     (cpu_req.wdata),
    .core_data_bit    (core_rdata),
    .core_address_bit (st_addr),
    .core_wdata       (st_wdata),
    .core_wmask       (st_wmask),
    .cpu_rdata        (st_rdata)
  );

  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  always_comb begin
    win_offset = cpu_req.addr - win_base;
    in_window  = enable && (cpu_req.addr >= win_base)
                 && (win_offset < win_size);                       // [RL13]
  end

  // ----------------------------------------------------------------
  // APB next state
  // ----------------------------------------------------------------
  always_comb begin
    next_mode     = mode;
    next_page     = page;
    next_enable   = enable;
    next_win_base = win_base;
    next_win_size = win_size;
    next_prdata   = prdata;
    next_pready   = 1'b0;
    next_pslverr  = 1'b0;
    if (psel && !penable) begin
      next_pready = 1'b1;
      next_prdata = 32'h0000_0000;
      case (paddr)
        REG_CTRL: begin
          next_prdata[CTRL_MODE_BIT]           = mode;
          next_prdata[CTRL_PAGE_LSB +: PAGE_W] = page;
          next_prdata[CTRL_EN_BIT]             = enable;
        end
        REG_WIN_BASE: next_prdata[15:0] = win_base;
        REG_WIN_SIZE: next_prdata[15:0] = win_size;
        REG_STATUS: begin
          next_prdata[1:0] = state;
          next_prdata[13:8] = hit_count;
        end
        REG_PIX_LO: next_prdata[17:0] = pix_pair[17:0];
        REG_PIX_HI: next_prdata[17:0] = pix_pair[35:18];
        default: next_pslverr = 1'b1;
      endcase
    end
    // Writes land only at the edge that completes the access
    if (psel && penable && pready && pwrite) begin
      case (paddr)
        REG_CTRL: begin
          next_mode   = cmwa_mode_t'(pwdata[CTRL_MODE_BIT]);      // [RL7] [RL16]
          next_page   = pwdata[CTRL_PAGE_LSB +: PAGE_W];          // [RL8] [RL14]
          next_enable = pwdata[CTRL_EN_BIT];
        end
        REG_WIN_BASE: next_win_base = pwdata[15:0];
        REG_WIN_SIZE: next_win_size = pwdata[15:0];
        default: next_pslverr = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Access next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_core_req  = core_req;
    next_cpu_ack   = 1'b0;
    next_cpu_rdata = cpu_rdata;
    next_pix_pair  = pix_pair;
    next_hit_count = hit_count;
    case (state)
      CMWA_IDLE: begin
        if (cpu_req.valid && in_window) begin
          next_core_req.valid = 1'b1;
          next_core_req.write = cpu_req.write;
          next_core_req.addr  = st_addr;                           // [RL16]
          next_core_req.wdata = st_wdata;
          next_core_req.wmask = cpu_req.write ? st_wmask : 18'h00000;
          next_state          = CMWA_BUSY;
        end
      end
      CMWA_BUSY: begin
        if (core_ack) begin
          next_core_req.valid = 1'b0;
          next_cpu_ack        = 1'b1;
          next_cpu_rdata      = st_rdata;
          next_hit_count      = hit_count + 6'h01;
          // Last even and last odd word read kept as pixel pair
          if (!core_req.write) begin
            if (core_req.addr[0]) next_pix_pair[35:18] = core_rdata; // [RL11] [RL12]
            else next_pix_pair[17:0] = core_rdata;                  // [RL11]
          end
          next_state = CMWA_DONE;
        end
      end
      CMWA_DONE: begin
        if (!cpu_req.valid) next_state = CMWA_IDLE;
      end
      default: next_state = CMWA_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode      <= CMWA_MODE_CPU;
      page      <= PAGE_RESET;
      enable    <= 1'b0;
      win_base  <= WIN_BASE_RESET;
      win_size  <= WIN_SIZE_RESET;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      state     <= CMWA_IDLE;
      core_req  <= '0;
      cpu_ack   <= 1'b0;
      cpu_rdata <= 16'h0000;
      pix_pair  <= 36'h0_0000_0000;
      hit_count <= 6'h00;
    end else if (clock_en) begin
      mode      <= next_mode;
      page      <= next_page;
      enable    <= next_enable;
      win_base  <= next_win_base;
      win_size  <= next_win_size;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
      state     <= next_state;
      core_req  <= next_core_req;
      cpu_ack   <= next_cpu_ack;
      cpu_rdata <= next_cpu_rdata;
      pix_pair  <= next_pix_pair;
      hit_count <= next_hit_count;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence issue_s;
    clock_en && state == CMWA_IDLE && cpu_req.valid && in_window;
  endsequence

  cpu_write_map_a: assert property (issue_s and mode == CMWA_MODE_CPU && cpu_req.write
    |=> core_req.wdata[7:0] == $past(cpu_req.wdata[7:0])
        && core_req.wdata[16:9] == $past(cpu_req.wdata[15:8])) // [RL1]
    else $error("cpu mode write data misplaced");

  cpu_write_mask_a: assert property (issue_s and mode == CMWA_MODE_CPU && cpu_req.write
    |=> !core_req.wmask[8] && !core_req.wmask[17]) // [RL2]
    else $error("cpu mode writes spare bits");

  cpu_read_map_a: assert property (clock_en && state == CMWA_BUSY && core_ack && mode == CMWA_MODE_CPU
    |=> cpu_ack && cpu_rdata == {$past(core_rdata[16:9]), $past(core_rdata[7:0])}) // [RL3]
    else $error("cpu mode read data misplaced");

  nine_write_half_a: assert property (issue_s and mode == CMWA_MODE_NINE && cpu_req.write
    |=> core_req.wmask == ($past(win_offset[1]) ? HIGH_HALF_MASK : LOW_HALF_MASK)) // [RL4]
    else $error("nine bit write half wrong");

  nine_read_mux_a: assert property (clock_en && state == CMWA_BUSY && core_ack && mode == CMWA_MODE_NINE
    |=> cpu_rdata[8:0] == ($past(win_offset[1]) ? $past(core_rdata[17:9])
                                                : $past(core_rdata[8:0]))) // [RL5]
    else $error("nine bit read mux wrong");

  nine_upper_zero_a: assert property (clock_en && state == CMWA_BUSY && core_ack && mode == CMWA_MODE_NINE
    |=> cpu_rdata[15:9] == 7'h00) // [RL6]
    else $error("nine bit upper bits driven");

  nine_page_addr_a: assert property (issue_s and mode == CMWA_MODE_NINE
    |=> core_req.addr == {$past(page), $past(win_offset[13:1])}) // [RL9] [RL15]
    else $error("nine bit address wrong");

  cpu_page_addr_a: assert property (issue_s and mode == CMWA_MODE_CPU
    |=> core_req.addr == {$past(page[2:0]), $past(win_offset[13:0])}) // [RL10] [RL14]
    else $error("cpu mode address wrong");

  window_only_a: assert property (clock_en && state == CMWA_IDLE && cpu_req.valid && !in_window
    |=> !core_req.valid) // [RL13]
    else $error("access outside window issued");

endmodule // cmwa_top
